//--- design/rtc_pkg.sv
// Purpose: shared constants and types for the clock bus and counter control
// Assumes: one system clock, oscillator edges arrive as one-cycle pulses
// Notes: counter fields are binary, unused high bits read as zero
package rtc_pkg;
    localparam logic [4:0] A_HUND = 5'h00;
    localparam logic [4:0] A_HOUR = 5'h01;
    localparam logic [4:0] A_MIN = 5'h02;
    localparam logic [4:0] A_SEC = 5'h03;
    localparam logic [4:0] A_MON = 5'h04;
    localparam logic [4:0] A_DATE = 5'h05;
    localparam logic [4:0] A_YEAR = 5'h06;
    localparam logic [4:0] A_DOW = 5'h07;
    localparam logic [4:0] A_MASK = 5'h10;
    localparam logic [4:0] A_CMD = 5'h11;
    localparam int CMD_RUN = 3;
    localparam int CMD_IEN = 4;
    localparam int CMD_TEST = 5;
    localparam int ST_HUND = 1;
    localparam int ST_TENTH = 2;
    localparam int ST_SEC = 3;
    localparam int ST_MIN = 4;
    localparam int ST_HOUR = 5;
    localparam int ST_DAY = 6;
    localparam int ST_GLOBAL = 7;
    localparam logic [7:0] CMD_RESET = 8'h00;
    localparam logic [7:0] MASK_RESET = 8'h00;
    localparam logic [23:0] BASE_HZ = 24'h000FA0;
    localparam logic [23:0] OSC_HZ0 = 24'h008000;
    localparam logic [23:0] OSC_HZ1 = 24'h100000;
    localparam logic [23:0] OSC_HZ2 = 24'h200000;
    localparam logic [23:0] OSC_HZ3 = 24'h400000;
    localparam logic [5:0] DIV_LAST = 6'h27;
    localparam logic [6:0] HUND_MAX = 7'h63;
    localparam logic [6:0] TENTH_DIV = 7'h0A;
    localparam logic [5:0] SEC_MAX = 6'h3B;
    localparam logic [4:0] HOUR_MAX = 5'h17;
    localparam logic [2:0] DOW_MAX = 3'h6;
    localparam logic [3:0] MON_MAX = 4'hC;
    localparam logic [6:0] YEAR_MAX = 7'h63;
    localparam logic [4:0] DATE_FIRST = 5'h01;
    localparam logic [3:0] MON_FIRST = 4'h1;

    typedef struct packed {
        logic [4:0] hour;
        logic [5:0] min;
        logic [5:0] sec;
        logic [3:0] mon;
        logic [4:0] date;
        logic [6:0] year;
        logic [2:0] dow;
    } rtc_time_t;

    typedef struct packed {
        logic [4:0] addr_lat;
        logic cs_lat_b;
        logic rd_d;
        logic rd_stat;
        logic [23:0] acc;
        logic [5:0] div;
        logic pend;
        logic [6:0] hund;
        rtc_time_t tm;
        rtc_time_t snap;
        logic [7:0] cmd;
        logic [7:0] mask;
        logic [7:0] stat;
        logic irq;
        logic [7:0] dout;
        logic doe;
    } rtc_state_t;
endpackage

//--- design/rtc_core.sv
// Purpose: parallel host bus, counter run control, snapshot latch, tick divider
// Assumes: all inputs synchronous to SYS_CLK, OSC_TICK one pulse per osc cycle
// Notes: interrupt pin is open drain, IRQ_OE high pulls it low
// Function
// - run bit gates the 100Hz count
// - hundredths read snapshots other counters
// - snapshot held until next hundredths read
// - tick during read postponed until read ends
// - ticks lost under overlong read strobe
// - read strobe with select drives data
// - write strobe with select stores data
// - select may stay low, strobes decode
// - address and select latched at strobe fall
// - test bit feeds oscillator to hundredths
// - mask seconds bit gives per-second interrupt
// - status read releases and rearms interrupt
// - frequency bits select divider to 4000Hz
// - interrupt needs enable bit and mask bit
// - unused counter bits read zero
// - status clears at read strobe rising edge
`timescale 1ns/1ns
module rtc_core
    import rtc_pkg::*;
(
    input wire logic SYS_CLK,
    input wire logic RST_B,
    input wire logic RD_B,
    input wire logic WR_B,
    input wire logic CS_B,
    input wire logic ALE,
    input wire logic [4:0] ADDR,
    input wire logic [7:0] DATA_IN,
    input wire logic OSC_TICK,
    output logic [7:0] DATA_OUT,
    output logic DATA_OE,
    output logic IRQ_O,
    output logic IRQ_OE
);
    rtc_state_t s_reg;
    rtc_state_t s_next;
    logic [4:0] eff_addr;
    logic eff_cs_b;
    logic rd_act;
    logic wr_act;
    logic rd_start;
    logic [23:0] osc_hz;
    logic [23:0] acc_sum;
    logic tick4k;
    logic tick100;
    logic adv;
    logic [6:0] hund_inc;
    logic c_sec;
    logic c_min;
    logic c_hour;
    logic c_day;
    logic c_mon;
    logic c_year;
    logic [7:0] stat_set;
    logic fire;
    logic stat_clr;

    function automatic logic [4:0] month_days(input logic [3:0] mon, input logic [6:0] yr);
        case (mon)
            4'h2: month_days = (yr[1:0] == 2'h0) ? 5'h1D : 5'h1C;
            4'h4, 4'h6, 4'h9, 4'hB: month_days = 5'h1E;
            default: month_days = 5'h1F;
        endcase
    endfunction

    always_comb begin
        // address latch transparent while strobe high
        eff_addr = ALE ? ADDR : s_reg.addr_lat;
        eff_cs_b = ALE ? CS_B : s_reg.cs_lat_b;
        rd_act = !RD_B && !eff_cs_b;
        wr_act = !WR_B && !eff_cs_b && RD_B;
        rd_start = rd_act && !s_reg.rd_d;
        case (s_reg.cmd[1:0])
            2'h0: osc_hz = OSC_HZ0;
            2'h1: osc_hz = OSC_HZ1;
            2'h2: osc_hz = OSC_HZ2;
            default: osc_hz = OSC_HZ3;
        endcase
        acc_sum = s_reg.acc + BASE_HZ;
        tick4k = OSC_TICK && (acc_sum >= osc_hz);
        tick100 = s_reg.cmd[CMD_TEST] ? OSC_TICK
            : (tick4k && s_reg.div == DIV_LAST);
        // one pending tick only, further ones dropped
        adv = s_reg.cmd[CMD_RUN] && (tick100 || s_reg.pend) && !rd_act;
        hund_inc = (s_reg.hund >= HUND_MAX) ? 7'h00 : s_reg.hund + 7'h01;
        c_sec = adv && s_reg.hund >= HUND_MAX;
        c_min = c_sec && s_reg.tm.sec >= SEC_MAX;
        c_hour = c_min && s_reg.tm.min >= SEC_MAX;
        c_day = c_hour && s_reg.tm.hour >= HOUR_MAX;
        c_mon = c_day && s_reg.tm.date >= month_days(s_reg.tm.mon, s_reg.tm.year);
        c_year = c_mon && s_reg.tm.mon >= MON_MAX;
        stat_set = 8'h00;
        stat_set[ST_HUND] = adv;
        stat_set[ST_TENTH] = adv && (hund_inc % TENTH_DIV) == 7'h00;
        stat_set[ST_SEC] = c_sec;
        stat_set[ST_MIN] = c_min;
        stat_set[ST_HOUR] = c_hour;
        stat_set[ST_DAY] = c_day;
        fire = s_reg.cmd[CMD_IEN] && |(stat_set[6:1] & s_reg.mask[6:1]);
        stat_clr = s_reg.rd_stat && !rd_act;

        s_next = s_reg;
        if (ALE) begin
            s_next.addr_lat = ADDR;
            s_next.cs_lat_b = CS_B;
        end
        s_next.rd_d = rd_act;
        s_next.rd_stat = rd_act && eff_addr == A_MASK;
        if (OSC_TICK) begin
            s_next.acc = tick4k ? acc_sum - osc_hz : acc_sum;
        end
        if (tick4k) begin
            s_next.div = (s_reg.div == DIV_LAST) ? 6'h00 : s_reg.div + 6'h01;
        end
        s_next.pend = s_reg.cmd[CMD_RUN] && rd_act && (tick100 || s_reg.pend);
        if (adv) begin
            s_next.hund = hund_inc;
        end
        if (c_sec) s_next.tm.sec = (s_reg.tm.sec >= SEC_MAX) ? 6'h00 : s_reg.tm.sec + 6'h01;
        if (c_min) s_next.tm.min = (s_reg.tm.min >= SEC_MAX) ? 6'h00 : s_reg.tm.min + 6'h01;
        if (c_hour) s_next.tm.hour = (s_reg.tm.hour >= HOUR_MAX) ? 5'h00 : s_reg.tm.hour + 5'h01;
        if (c_day) begin
            s_next.tm.dow = (s_reg.tm.dow >= DOW_MAX) ? 3'h0 : s_reg.tm.dow + 3'h1;
            s_next.tm.date = c_mon ? DATE_FIRST : s_reg.tm.date + 5'h01;
        end
        if (c_mon) s_next.tm.mon = c_year ? MON_FIRST : s_reg.tm.mon + 4'h1;
        if (c_year) s_next.tm.year = (s_reg.tm.year >= YEAR_MAX) ? 7'h00 : s_reg.tm.year + 7'h01;
        // new flags win over the clear
        s_next.stat = (stat_clr ? 8'h00 : s_reg.stat) | stat_set;
        if (fire) begin
            s_next.stat[ST_GLOBAL] = 1'b1;
        end
        s_next.irq = fire || (s_reg.irq && !stat_clr);
        if (rd_start && eff_addr == A_HUND) begin
            s_next.snap = s_reg.tm;
        end
        s_next.doe = rd_act;
        s_next.dout = 8'h00;
        if (rd_act) begin
            case (eff_addr)
                A_HUND: s_next.dout = {1'b0, s_reg.hund};
                A_HOUR: s_next.dout = {3'h0, s_reg.snap.hour};
                A_MIN: s_next.dout = {2'h0, s_reg.snap.min};
                A_SEC: s_next.dout = {2'h0, s_reg.snap.sec};
                A_MON: s_next.dout = {4'h0, s_reg.snap.mon};
                A_DATE: s_next.dout = {3'h0, s_reg.snap.date};
                A_YEAR: s_next.dout = {1'b0, s_reg.snap.year};
                A_DOW: s_next.dout = {5'h00, s_reg.snap.dow};
                A_MASK: s_next.dout = s_reg.stat;
                A_CMD: s_next.dout = s_reg.cmd;
                default: s_next.dout = 8'h00;
            endcase
        end
        if (wr_act) begin
            case (eff_addr)
                A_HUND: s_next.hund = DATA_IN[6:0];
                A_HOUR: s_next.tm.hour = DATA_IN[4:0];
                A_MIN: s_next.tm.min = DATA_IN[5:0];
                A_SEC: s_next.tm.sec = DATA_IN[5:0];
                A_MON: s_next.tm.mon = DATA_IN[3:0];
                A_DATE: s_next.tm.date = DATA_IN[4:0];
                A_YEAR: s_next.tm.year = DATA_IN[6:0];
                A_DOW: s_next.tm.dow = DATA_IN[2:0];
                A_MASK: s_next.mask = DATA_IN;
                A_CMD: s_next.cmd = DATA_IN;
                default: s_next.cmd = s_reg.cmd;
            endcase
        end
    end

    always_ff @(posedge SYS_CLK or negedge RST_B) begin
        if (!RST_B) begin
            s_reg <= '0;
            s_reg.cs_lat_b <= 1'b1;
            s_reg.cmd <= CMD_RESET;
            s_reg.mask <= MASK_RESET;
            s_reg.tm.date <= DATE_FIRST;
            s_reg.tm.mon <= MON_FIRST;
        end else begin
            s_reg <= s_next;
        end
    end

    assign DATA_OUT = s_reg.dout;
    assign DATA_OE = s_reg.doe;
    assign IRQ_OE = s_reg.irq;
    assign IRQ_O = 1'b0;

    default clocking cb @(posedge SYS_CLK); endclocking
    default disable iff (!RST_B);

    AST_STOPPED: assert property (
        !s_reg.cmd[CMD_RUN] && !wr_act |=> $stable(s_reg.hund))
        else $error("hundredths moved while stopped");
    AST_SNAP_TAKE: assert property (
        rd_start && eff_addr == A_HUND |=> s_reg.snap == $past(s_reg.tm))
        else $error("snapshot not captured");
    AST_SNAP_HOLD: assert property (
        !(rd_start && eff_addr == A_HUND) |=> $stable(s_reg.snap))
        else $error("snapshot changed without hundredths read");
    AST_POSTPONE: assert property (rd_act && !wr_act |=> $stable(s_reg.hund))
        else $error("count advanced during read");
    AST_PEND_APPLY: assert property (
        s_reg.pend && !rd_act && !wr_act |=> s_reg.hund != $past(s_reg.hund))
        else $error("postponed tick not applied");
    AST_DRIVE: assert property (rd_act |=> DATA_OE)
        else $error("data bus not driven during read");
    AST_DRIVE_OFF: assert property (!rd_act |=> !DATA_OE)
        else $error("data bus driven without read");
    AST_CMD_WR: assert property (
        wr_act && eff_addr == A_CMD |=> s_reg.cmd == $past(DATA_IN))
        else $error("command write lost");
    AST_ALE_HOLD: assert property (!ALE |=> $stable(s_reg.addr_lat))
        else $error("address latch moved while closed");
    AST_TEST_MODE: assert property (
        s_reg.cmd[CMD_TEST] && s_reg.cmd[CMD_RUN] && OSC_TICK && !rd_act && !wr_act
        |=> s_reg.hund != $past(s_reg.hund))
        else $error("test mode did not count");
    AST_IRQ_GATE: assert property (
        $rose(IRQ_OE) |-> $past(s_reg.cmd[CMD_IEN]) && $past(|s_reg.mask[6:1]))
        else $error("interrupt without enable and mask");
    AST_STAT_CLR: assert property (
        stat_clr && !adv |=> s_reg.stat == 8'h00 && !IRQ_OE)
        else $error("status not cleared after read");
    AST_UNUSED_ZERO: assert property (
        rd_act && eff_addr == A_SEC |=> DATA_OUT[7:6] == 2'h0)
        else $error("unused bits not zero");

    COV_SNAP: cover property (rd_start && eff_addr == A_HUND);
    COV_PEND: cover property (s_reg.pend ##[1:20] adv);
    COV_IRQ: cover property ($rose(IRQ_OE) ##[1:50] $fell(IRQ_OE));
    COV_SEC: cover property (c_sec);
endmodule

//--- verif/rtc_host_model.sv
// Purpose: host processor model for the clock's parallel bus
// Assumes: bus lines change just after rising clock edges
// Notes: released lines show inverted values; mux mode latches the address
`timescale 1ns/1ns
module rtc_host_model (
    input wire logic clk,
    input wire logic [7:0] data_out,
    output logic rd_b = 1'b1,
    output logic wr_b = 1'b1,
    output logic cs_b = 1'b1,
    output logic ale = 1'b1,
    output logic [4:0] addr = 5'h1F,
    output logic [7:0] data_in = 8'hFF
);
    logic mux = 1'b0;
    logic sel_b = 1'b0;
    logic cs_idle = 1'b1;
    task automatic put_addr(input logic [4:0] a);
        @(posedge clk) begin
            ale <= 1'b1;
            addr <= a;
            cs_b <= sel_b;
        end
        if (mux) begin
            @(posedge clk) ale <= 1'b0;
            @(posedge clk) begin
                addr <= ~a;
                cs_b <= cs_idle;
            end
        end
    endtask
    task automatic release_bus;
        rd_b <= 1'b1;
        wr_b <= 1'b1;
        cs_b <= cs_idle;
        addr <= ~addr;
        data_in <= ~data_in;
    endtask
    task automatic wr(input logic [4:0] a, input logic [7:0] v);
        put_addr(a);
        @(posedge clk) begin
            wr_b <= 1'b0;
            data_in <= v;
        end
        @(posedge clk) release_bus();
    endtask
    task automatic rd(input logic [4:0] a, input int hold, output logic [7:0] d);
        put_addr(a);
        @(posedge clk) rd_b <= 1'b0;
        repeat (2 + hold) @(posedge clk);
        #1 d = data_out;
        @(posedge clk) release_bus();
    endtask
endmodule

//--- verif/rtc_bus_and_counter_control_tb.sv
// Purpose: self-checking bench for bus access and counter control
// Assumes: host model drives the bus, bench drives oscillator ticks
// Notes: test mode gives one hundredths step per oscillator tick
`timescale 1ns/1ns
module rtc_bus_and_counter_control_tb;
    import rtc_pkg::*;
    logic clk = 1'b0;
    logic rst_b = 1'b0;
    logic osc = 1'b0;
    logic rd_b, wr_b, cs_b, ale, doe, irq, irq_oe;
    logic [4:0] addr;
    logic [7:0] din, dout, d;
    int errors = 0;
    int num_checks = 0;
    always #5 clk = ~clk;
    rtc_core u_rtc_core (.SYS_CLK(clk), .RST_B(rst_b), .RD_B(rd_b), .WR_B(wr_b),
        .CS_B(cs_b), .ALE(ale), .ADDR(addr), .DATA_IN(din), .OSC_TICK(osc),
        .DATA_OUT(dout), .DATA_OE(doe), .IRQ_O(irq), .IRQ_OE(irq_oe));
    rtc_host_model u_rtc_host_model (.clk(clk), .data_out(dout), .rd_b(rd_b),
        .wr_b(wr_b), .cs_b(cs_b), .ale(ale), .addr(addr), .data_in(din));
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        num_checks++;
        if (seen !== exp) begin
            errors++;
            $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic tally_and_finish;
        $display("checks %0d errors %0d", num_checks, errors);
        if (errors == 0 && num_checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    task automatic wr(input logic [4:0] a, input logic [7:0] v);
        u_rtc_host_model.wr(a, v);
    endtask
    task automatic rdc(input logic [4:0] a, input logic [7:0] e);
        u_rtc_host_model.rd(a, 0, d);
        check(d, e);
    endtask
    task automatic pulse(input int n);
        repeat (n) begin
            @(posedge clk) osc <= 1'b1;
            @(posedge clk) osc <= 1'b0;
        end
    endtask
    task automatic irq_is(input logic e);
        repeat (3) @(posedge clk);
        #1;
        check({7'h00, irq_oe}, {7'h00, e});
        check({7'h00, irq}, 8'h00);
    endtask
    initial begin
        repeat (20000) @(posedge clk);
        errors++;
        tally_and_finish();
    end
    initial begin
        repeat (3) @(posedge clk);
        rst_b <= 1'b1;
        @(posedge clk);
        #1;
        check({6'h00, doe, irq_oe}, 8'h00);
        rdc(A_CMD, CMD_RESET);
        wr(A_CMD, 8'h07);
        rdc(A_CMD, 8'h07);
        rdc(5'h08, 8'h00);
        irq_is(1'b0);
        check({7'h00, doe}, 8'h00);
        wr(A_CMD, 8'h00);
        wr(A_SEC, 8'h05);
        wr(A_MIN, 8'hFF);
        rdc(A_HUND, 8'h00);
        wr(A_SEC, 8'h09);
        rdc(A_SEC, 8'h05);
        rdc(A_MIN, 8'h3F);
        rdc(A_HUND, 8'h00);
        rdc(A_SEC, 8'h09);
        wr(A_CMD, 8'h20);
        pulse(3);
        rdc(A_HUND, 8'h00);
        wr(A_CMD, 8'h28);
        pulse(5);
        rdc(A_HUND, 8'h05);
        fork
            u_rtc_host_model.rd(A_HUND, 6, d);
            begin
                repeat (3) @(posedge clk);
                pulse(2);
            end
        join
        check(d, 8'h05);
        rdc(A_HUND, 8'h06);
        wr(A_MASK, 8'h02);
        u_rtc_host_model.rd(A_MASK, 0, d);
        pulse(1);
        irq_is(1'b0);
        rdc(A_MASK, 8'h02);
        rdc(A_MASK, 8'h00);
        wr(A_CMD, 8'h38);
        pulse(1);
        irq_is(1'b1);
        rdc(A_MASK, 8'h82);
        irq_is(1'b0);
        wr(A_CMD, 8'h20);
        wr(A_HUND, 8'h62);
        wr(A_MASK, 8'h00);
        wr(A_CMD, 8'h38);
        wr(A_MASK, 8'h08);
        u_rtc_host_model.rd(A_MASK, 0, d);
        pulse(1);
        irq_is(1'b0);
        pulse(1);
        irq_is(1'b1);
        rdc(A_MASK, 8'h8E);
        u_rtc_host_model.mux = 1'b1;
        wr(A_CMD, 8'h13);
        rdc(A_CMD, 8'h13);
        u_rtc_host_model.mux = 1'b0;
        u_rtc_host_model.sel_b = 1'b1;
        wr(A_CMD, 8'h00);
        u_rtc_host_model.sel_b = 1'b0;
        u_rtc_host_model.cs_idle = 1'b0;
        rdc(A_CMD, 8'h13);
        wr(A_CMD, 8'h00);
        wr(A_HUND, 8'h00);
        wr(A_CMD, 8'h08);
        repeat (290) @(posedge clk) osc <= 1'b1;
        @(posedge clk) osc <= 1'b0;
        rdc(A_HUND, 8'h00);
        repeat (70) @(posedge clk) osc <= 1'b1;
        @(posedge clk) osc <= 1'b0;
        rdc(A_HUND, 8'h01);
        wr(A_CMD, 8'h09);
        repeat (9100) @(posedge clk) osc <= 1'b1;
        @(posedge clk) osc <= 1'b0;
        rdc(A_HUND, 8'h01);
        repeat (100) @(posedge clk) osc <= 1'b1;
        @(posedge clk) osc <= 1'b0;
        rdc(A_HUND, 8'h02);
        tally_and_finish();
    end
endmodule
